/* File: src/rpd_pkg.sv */
// Package for the region protection and address decode block.
// Assumes one 100 MHz system clock and 32-bit byte addresses.
package rpd_pkg;
   localparam int          RPD_NUM_REGIONS  = 8;          // Number of protection regions.
   localparam int          RPD_NUM_SUBREG   = 8;          // Subregions in one region.
   localparam int          RPD_ADDR_W       = 32;         // Address width.
   localparam int          RPD_SLOT_SHIFT   = 14;         // 16 kB slot boundary bit.
   localparam int          RPD_AHB_SIZE_LOG = 21;         // 2 MB high-speed window.
   localparam int          RPD_APB_SIZE_LOG = 20;         // 1 MB low-speed window.
   localparam int          RPD_AHB_SLOTS    = 128;        // High-speed peripheral slots.
   localparam int          RPD_APB_SLOTS    = 64;         // Low-speed peripheral slots.
   localparam logic [31:0] RPD_AHB_BASE     = 32'h5000_0000; // Default high-speed base.
   localparam logic [31:0] RPD_APB_BASE     = 32'h4000_0000; // Default low-speed base.
   localparam logic [31:0] RPD_VEC_BASE     = 32'h0000_0000; // Vector area start.
   localparam logic [31:0] RPD_VEC_SIZE     = 32'h0000_0400; // Vector area length.
   localparam logic [31:0] RPD_VEC_ALT      = 32'h1000_0000; // Default remap target.
   localparam logic [1:0]  RPD_PERM_NONE    = 2'h0;       // Access disabled.
   localparam logic [1:0]  RPD_PERM_RO      = 2'h1;       // Read only.
   localparam logic [1:0]  RPD_PERM_RW      = 2'h3;       // Read and write.
   // Classification of a decoded address.
   typedef enum logic [1:0] {RPD_AREA_MEM, RPD_AREA_AHB, RPD_AREA_APB} rpd_area_t;
endpackage : rpd_pkg

/* File: src/rpd_region_match.sv */
// One protection region comparator with eight subregion disable bits.
// Assumes a power-of-two sized region, size at least eight bytes.
`timescale 1ns/100ps
module rpd_region_match (
   // Region configuration.
   input  wire logic        enable_i,
   input  wire logic [31:0] base_i,
   input  wire logic [4:0]  size_log_i,
   input  wire logic [7:0]  sub_disable_i,
   // Address under test.
   input  wire logic [31:0] addr_i,
   // Match result.
   output logic             hit_o
);
   logic [31:0] mask;      // Ones over the offset bits.
   logic [2:0]  sub_index; // Subregion selected by the address.

   // Compare the upper bits and pick the subregion from the top three offset bits.
   always_comb begin
      mask      = (32'h0000_0001 << size_log_i) - 32'h0000_0001;
      sub_index = 3'(addr_i >> (size_log_i - 5'd3));
      hit_o     = enable_i && ((addr_i & ~mask) == (base_i & ~mask))
                  && !sub_disable_i[sub_index];
   end
endmodule : rpd_region_match

/* File: src/rpd_top.sv */
// Region protection check and peripheral decode for core bus accesses.
// Assumes the core holds its request until done or error is returned,
// and that region configuration is stable while a request is pending.
`timescale 1ns/100ps
// How it works
// - Eight regions, each with eight subregions.
// - Unmapped access blocked, fault raised.
// - Permission violation blocked, same fault.
// - Read-only region rejects writes only.
// - Disabled region rejects every access.
// - High-speed area: 2 MB, 128 slots.
// - Low-speed area: 1 MB, 64 slots.
// - Every slot spans 16 kB.
// - Vector area remappable to alternate memory.
module rpd_top #(
   parameter int NREG = rpd_pkg::RPD_NUM_REGIONS
) (
   // Clock and reset.
   input  wire logic                 clk_sys_i,
   input  wire logic                 reset_i,
   // Region configuration, one field per region.
   input  wire logic [NREG-1:0]      reg_enable_i,
   input  wire logic [NREG*32-1:0]   reg_base_i,
   input  wire logic [NREG*5-1:0]    reg_size_log_i,
   input  wire logic [NREG*8-1:0]    reg_sub_dis_i,
   input  wire logic [NREG*2-1:0]    reg_perm_i,
   // Vector remap control.
   input  wire logic                 remap_en_i,
   input  wire logic [31:0]          remap_base_i,
   // Core request.
   input  wire logic                 req_valid_i,
   input  wire logic                 req_write_i,
   input  wire logic [31:0]          req_addr_i,
   input  wire logic [31:0]          req_wdata_i,
   // Target side.
   output logic                      tgt_valid_o,
   output logic                      tgt_write_o,
   output logic [31:0]               tgt_addr_o,
   output logic [31:0]               tgt_wdata_o,
   output logic [1:0]                tgt_area_o,
   output logic [6:0]                tgt_slot_o,
   input  wire logic                 tgt_ready_i,
   input  wire logic [31:0]          tgt_rdata_i,
   // Answer to the core.
   output logic                      rsp_done_o,
   output logic                      rsp_error_o,
   output logic [31:0]               rsp_rdata_o,
   output logic                      fault_o
);
   import rpd_pkg::*;

   // Per-region hit flags from the comparators.
   logic [NREG-1:0] hit;
   // Comparator bank, one instance per region, each with eight subregions.
   generate
      for (genvar g = 0; g < NREG; g++) begin : g_reg
         rpd_region_match u_match (
            .enable_i      (reg_enable_i[g]),
            .base_i        (reg_base_i[g*32 +: 32]),
            .size_log_i    (reg_size_log_i[g*5 +: 5]),
            .sub_disable_i (reg_sub_dis_i[g*8 +: 8]),
            .addr_i        (req_addr_i),
            .hit_o         (hit[g])
         );
      end
   endgenerate

   // Check outcome of the current request.
   logic       any_hit;   // Some region claims the address.
   logic [1:0] perm;      // Permission of the highest matching region.
   logic       allow;     // Access may proceed.
   logic [31:0] eff_addr; // Address after vector remap.
   rpd_area_t  area;      // Decoded area.
   logic [6:0] slot;      // Decoded slot.

   // Highest numbered matching region wins, then permission and decode.
   always_comb begin
      any_hit = 1'b0;
      perm    = RPD_PERM_NONE;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            any_hit = 1'b1;
            perm    = reg_perm_i[i*2 +: 2];
         end
      end
      // Unmapped fails; disabled fails; read-only refuses writes.
      if (!any_hit) begin
         allow = 1'b0;
      end else if (perm == RPD_PERM_NONE) begin
         allow = 1'b0;
      end else if (perm == RPD_PERM_RO) begin
         allow = !req_write_i;
      end else begin
         allow = 1'b1;
      end
      // Vector area accesses go to the alternate memory when remapped.
      eff_addr = req_addr_i;
      if (remap_en_i && req_addr_i >= RPD_VEC_BASE
          && req_addr_i < RPD_VEC_BASE + RPD_VEC_SIZE) begin
         eff_addr = remap_base_i + (req_addr_i - RPD_VEC_BASE);
      end
      // Windows are 2 MB and 1 MB, sliced into 16 kB slots.
      area = RPD_AREA_MEM;
      slot = 7'h00;
      if ((eff_addr >> RPD_AHB_SIZE_LOG) == (RPD_AHB_BASE >> RPD_AHB_SIZE_LOG)) begin
         area = RPD_AREA_AHB;
         slot = 7'(eff_addr[RPD_AHB_SIZE_LOG-1:RPD_SLOT_SHIFT]);
      end else if ((eff_addr >> RPD_APB_SIZE_LOG) == (RPD_APB_BASE >> RPD_APB_SIZE_LOG)) begin
         area = RPD_AREA_APB;
         slot = {1'b0, eff_addr[RPD_APB_SIZE_LOG-1:RPD_SLOT_SHIFT]};
      end
   end

   // Transaction state.
   typedef enum {RPD_IDLE, RPD_BUSY, RPD_RESP} rpd_state_t;
   rpd_state_t  state_reg, state_next;
   logic        tv_reg, tv_next, tw_reg, tw_next;
   logic [31:0] ta_reg, ta_next, td_reg, td_next, rd_reg, rd_next;
   logic [1:0]  ar_reg, ar_next;
   logic [6:0]  sl_reg, sl_next;
   logic        dn_reg, dn_next, er_reg, er_next, ft_reg, ft_next;

   // Next-state logic: forward allowed requests, answer refused ones with error.
   always_comb begin
      state_next = state_reg;
      tv_next    = tv_reg;
      tw_next    = tw_reg;
      ta_next    = ta_reg;
      td_next    = td_reg;
      ar_next    = ar_reg;
      sl_next    = sl_reg;
      rd_next    = rd_reg;
      // Answer flags are single-cycle pulses.
      dn_next    = 1'b0;
      er_next    = 1'b0;
      ft_next    = 1'b0;
      case (state_reg)
         RPD_IDLE: begin
            if (req_valid_i) begin
               if (allow) begin
                  tv_next = 1'b1;
                  tw_next = req_write_i;
                  ta_next = eff_addr;
                  td_next = req_wdata_i;
                  ar_next = 2'(area);
                  sl_next = slot;
                  state_next = RPD_BUSY;
               end else begin
                  // Nothing reaches the target; error and fault together.
                  er_next = 1'b1;
                  ft_next = 1'b1;
                  rd_next = 32'h0000_0000;
                  state_next = RPD_RESP;
               end
            end
         end
         RPD_BUSY: begin
            if (tgt_ready_i) begin
               tv_next = 1'b0;
               dn_next = 1'b1;
               rd_next = tw_reg ? 32'h0000_0000 : tgt_rdata_i;
               state_next = RPD_RESP;
            end
         end
         RPD_RESP: begin
            // One idle cycle lets the core drop its request.
            state_next = RPD_IDLE;
         end
         default: state_next = RPD_IDLE;
      endcase
   end

   // Register the transaction state.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg <= RPD_IDLE;
         tv_reg    <= 1'b0;
         tw_reg    <= 1'b0;
         ta_reg    <= 32'h0000_0000;
         td_reg    <= 32'h0000_0000;
         rd_reg    <= 32'h0000_0000;
         ar_reg    <= 2'h0;
         sl_reg    <= 7'h00;
         dn_reg    <= 1'b0;
         er_reg    <= 1'b0;
         ft_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         tv_reg    <= tv_next;
         tw_reg    <= tw_next;
         ta_reg    <= ta_next;
         td_reg    <= td_next;
         rd_reg    <= rd_next;
         ar_reg    <= ar_next;
         sl_reg    <= sl_next;
         dn_reg    <= dn_next;
         er_reg    <= er_next;
         ft_reg    <= ft_next;
      end
   end

   // Outputs straight from flip-flops.
   assign tgt_valid_o = tv_reg;
   assign tgt_write_o = tw_reg;
   assign tgt_addr_o  = ta_reg;
   assign tgt_wdata_o = td_reg;
   assign tgt_area_o  = ar_reg;
   assign tgt_slot_o  = sl_reg;
   assign rsp_done_o  = dn_reg;
   assign rsp_error_o = er_reg;
   assign rsp_rdata_o = rd_reg;
   assign fault_o     = ft_reg;

   // Unmapped request from idle gives error and fault next cycle.
   property p_unmapped;
      @(posedge clk_sys_i) disable iff (reset_i)
      (state_reg == RPD_IDLE && req_valid_i && !any_hit) |=> (rsp_error_o && fault_o);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not faulted");
   // Disabled region never forwards.
   property p_disabled;
      @(posedge clk_sys_i) disable iff (reset_i)
      (state_reg == RPD_IDLE && req_valid_i && any_hit && perm == RPD_PERM_NONE)
      |=> !tgt_valid_o ##1 !tgt_valid_o;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled region forwarded");
   // Read-only write faults.
   property p_ro_write;
      @(posedge clk_sys_i) disable iff (reset_i)
      (state_reg == RPD_IDLE && req_valid_i && any_hit && perm == RPD_PERM_RO && req_write_i)
      |=> fault_o;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write allowed");
   // Read-only read is forwarded.
   property p_ro_read;
      @(posedge clk_sys_i) disable iff (reset_i)
      (state_reg == RPD_IDLE && req_valid_i && any_hit && perm == RPD_PERM_RO && !req_write_i)
      |=> tgt_valid_o && !fault_o;
   endproperty
   a_ro_read: assert property (p_ro_read) else $error("read-only read blocked");
   // Fault and error always coincide, with no target write.
   property p_fault_err;
      @(posedge clk_sys_i) disable iff (reset_i)
      fault_o |-> rsp_error_o && !rsp_done_o && !tgt_valid_o;
   endproperty
   a_fault_err: assert property (p_fault_err) else $error("fault without error");
   // High-speed slot matches the address bits above 16 kB.
   property p_ahb_slot;
      @(posedge clk_sys_i) disable iff (reset_i)
      $rose(tgt_valid_o) && tgt_area_o == 2'(RPD_AREA_AHB)
      |-> tgt_slot_o == tgt_addr_o[20:14];
   endproperty
   a_ahb_slot: assert property (p_ahb_slot) else $error("bad high-speed slot");
   // Low-speed slot stays below 64.
   property p_apb_slot;
      @(posedge clk_sys_i) disable iff (reset_i)
      $rose(tgt_valid_o) && tgt_area_o == 2'(RPD_AREA_APB)
      |-> tgt_slot_o == {1'b0, tgt_addr_o[19:14]};
   endproperty
   a_apb_slot: assert property (p_apb_slot) else $error("bad low-speed slot");
   // Remapped vector access reaches the alternate base.
   property p_remap;
      @(posedge clk_sys_i) disable iff (reset_i)
      (state_reg == RPD_IDLE && req_valid_i && allow && remap_en_i && req_addr_i < RPD_VEC_SIZE)
      |=> tgt_addr_o == remap_base_i + $past(req_addr_i);
   endproperty
   a_remap: assert property (p_remap) else $error("vector remap missed");
endmodule : rpd_top

/* File: testbench/rpd_tgt_model.sv */
// Target model standing behind the protection block: memory and peripherals alike.
// Assumes the block holds each request until ready is seen at a rising edge.
`timescale 1ns/100ps
module rpd_tgt_model (
   // Clock and reset.
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Request from the block.
   input  wire logic        tgt_valid_i,
   input  wire logic        tgt_write_i,
   input  wire logic [31:0] tgt_addr_i,
   input  wire logic [31:0] tgt_wdata_i,
   // Wait states before ready, set by the bench.
   input  wire logic [3:0]  delay_i,
   // Answer to the block.
   output logic             tgt_ready_o,
   output logic [31:0]      tgt_rdata_o,
   // Log of completed writes.
   output logic [7:0]       wr_count_o,
   output logic [31:0]      wr_data_o
);
   logic [3:0]  wait_reg;  // Cycles the current request has waited.
   logic [31:0] noise_reg; // Changes every cycle, so stale data never looks valid.
   // Ready comes after the programmed number of wait cycles.
   assign tgt_ready_o = tgt_valid_i && (wait_reg == delay_i);
   // Read data is a known function of the address only while ready is high.
   assign tgt_rdata_o = tgt_ready_o ? (tgt_addr_i ^ 32'hA5A5_0000) : noise_reg;
   // Counts wait cycles and logs every write that completes.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wait_reg   <= 4'h0;
         noise_reg  <= 32'h0000_0000;
         wr_count_o <= 8'h00;
         wr_data_o  <= 32'h0000_0000;
      end else begin
         noise_reg <= ~noise_reg + 32'h0001_2345;
         wait_reg  <= (tgt_valid_i && !tgt_ready_o) ? wait_reg + 4'h1 : 4'h0;
         if (tgt_ready_o && tgt_write_i) begin
            wr_count_o <= wr_count_o + 8'h01;
            wr_data_o  <= tgt_wdata_i;
         end
      end
   end
endmodule : rpd_tgt_model

/* File: testbench/tb_rpd_top.sv */
// Self-checking bench for the protection and decode block with a target model.
// Assumes the package constants and a 100 MHz clock; inputs change at falling edges.
`timescale 1ns/100ps
module tb_rpd_top;
   import rpd_pkg::*;
   logic         clk_sys_i = 0, reset_i = 1, remap_en_i = 0, req_valid_i = 0, req_write_i = 0;
   logic [7:0]   reg_enable_i = '0;
   logic [255:0] reg_base_i = '0;
   logic [39:0]  reg_size_log_i = '0;
   logic [63:0]  reg_sub_dis_i = '0;
   logic [15:0]  reg_perm_i = '0;
   logic [31:0]  remap_base_i = 32'h1000_0000, req_addr_i = '0, req_wdata_i = '0;
   logic         tgt_valid_o, tgt_write_o, tgt_ready_i, rsp_done_o, rsp_error_o, fault_o;
   logic [31:0]  tgt_addr_o, tgt_wdata_o, tgt_rdata_i, rsp_rdata_o, wr_data;
   logic [1:0]   tgt_area_o;
   logic [6:0]   tgt_slot_o;
   logic [7:0]   wr_count;
   logic [3:0]   delay = '0;
   int           fails = 0, total_checks = 0;
   // Device under test with all eight regions.
   rpd_top #(.NREG(8)) DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .reg_enable_i(reg_enable_i), .reg_base_i(reg_base_i), .reg_size_log_i(reg_size_log_i),
      .reg_sub_dis_i(reg_sub_dis_i), .reg_perm_i(reg_perm_i), .remap_en_i(remap_en_i),
      .remap_base_i(remap_base_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .tgt_valid_o(tgt_valid_o),
      .tgt_write_o(tgt_write_o), .tgt_addr_o(tgt_addr_o), .tgt_wdata_o(tgt_wdata_o),
      .tgt_area_o(tgt_area_o), .tgt_slot_o(tgt_slot_o), .tgt_ready_i(tgt_ready_i),
      .tgt_rdata_i(tgt_rdata_i), .rsp_done_o(rsp_done_o), .rsp_error_o(rsp_error_o),
      .rsp_rdata_o(rsp_rdata_o), .fault_o(fault_o));
   // Target behind the block.
   rpd_tgt_model u_tgt (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tgt_valid_i(tgt_valid_o),
      .tgt_write_i(tgt_write_o), .tgt_addr_i(tgt_addr_o), .tgt_wdata_i(tgt_wdata_o),
      .delay_i(delay), .tgt_ready_o(tgt_ready_i), .tgt_rdata_o(tgt_rdata_i),
      .wr_count_o(wr_count), .wr_data_o(wr_data));
   // Free-running system clock.
   always #5 clk_sys_i = ~clk_sys_i;
   // Compares one value and counts the outcome.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   // Loads the configuration of one region.
   task automatic set_reg(input int g, input logic [31:0] b, input logic [4:0] s,
                          input logic [7:0] sd, input logic [1:0] p);
      reg_enable_i[g] = 1'b1;
      reg_base_i[g*32+:32] = b;
      reg_size_log_i[g*5+:5] = s;
      reg_sub_dis_i[g*8+:8] = sd;
      reg_perm_i[g*2+:2] = p;
   endtask : set_reg
   // One core access; judges the target request, the answer and the write log.
   task automatic acc(input logic w, input logic [31:0] a, input logic ok,
                      input logic [31:0] ta, input logic [1:0] ar, input logic [6:0] sl);
      int n;
      logic seen;
      logic [7:0] wc;
      n = 0;
      seen = 1'b0;
      wc = wr_count;
      @(negedge clk_sys_i);
      req_valid_i = 1'b1;
      req_write_i = w;
      req_addr_i = a;
      req_wdata_i = ~a;
      while (!(rsp_done_o === 1'b1 || rsp_error_o === 1'b1) && n < 50) begin
         @(negedge clk_sys_i);
         n++;
         if (tgt_valid_o === 1'b1 && !seen) begin
            seen = 1'b1;
            check({tgt_addr_o}, ta, "target address");
            check(32'({tgt_write_o, tgt_area_o, tgt_slot_o}), 32'({w, ar, sl}), "decode");
         end
      end
      if (n >= 50) begin
         fails++;
         stop_test();
      end
      req_valid_i = 1'b0;
      check(32'({rsp_done_o, rsp_error_o, fault_o, seen}), 32'({ok, !ok, !ok, ok}), "answer");
      check(rsp_rdata_o, (ok && !w) ? (ta ^ 32'hA5A5_0000) : 32'h0000_0000, "rdata");
      check(32'(wr_count), 32'(wc + 8'(ok && w)), "write count");
      if (ok && w) check(wr_data, ~a, "write data");
   endtask : acc
   // Outputs are quiet right after reset.
   task automatic t_reset();
      check(32'({tgt_valid_o, rsp_done_o, rsp_error_o, fault_o}), 32'h0, "idle");
      $display("test reset done");
   endtask : t_reset
   // Window and slot decode, including the top slot of each window.
   task automatic t_decode();
      acc(0, 32'h5001_C000, 1, 32'h5001_C000, 1, 7);
      acc(1, 32'h501F_FFFC, 1, 32'h501F_FFFC, 1, 127);
      acc(0, 32'h4003_4000, 1, 32'h4003_4000, 2, 13);
      acc(0, 32'h400F_FFFC, 1, 32'h400F_FFFC, 2, 63);
      $display("test decode done");
   endtask : t_decode
   // Addresses outside every region are refused.
   task automatic t_unmapped();
      acc(1, 32'h6000_0000, 0, 0, 0, 0);
      acc(0, 32'h4010_0000, 0, 0, 0, 0);
      $display("test unmapped done");
   endtask : t_unmapped
   // Read-only slot over a read-write window: reads pass, writes fault.
   task automatic t_readonly();
      acc(0, 32'h5000_3FFC, 1, 32'h5000_3FFC, 1, 0);
      acc(1, 32'h5000_0010, 0, 0, 0, 0);
      acc(1, 32'h5000_4000, 1, 32'h5000_4000, 1, 1);
      // With the read-only region switched off the read-write window decides.
      reg_enable_i[3] = 1'b0;
      acc(1, 32'h5000_0010, 1, 32'h5000_0010, 1, 0);
      reg_enable_i[3] = 1'b1;
      $display("test read-only done");
   endtask : t_readonly
   // Access-disabled slot refuses both directions; its neighbour passes.
   task automatic t_disabled();
      acc(0, 32'h4000_8000, 0, 0, 0, 0);
      acc(1, 32'h4000_BFFC, 0, 0, 0, 0);
      acc(0, 32'h4000_C000, 1, 32'h4000_C000, 2, 3);
      $display("test disabled done");
   endtask : t_disabled
   // The top eighth of region zero is switched off.
   task automatic t_subregion();
      acc(0, 32'h1BFF_FFFC, 1, 32'h1BFF_FFFC, 0, 0);
      acc(1, 32'h1C00_0000, 0, 0, 0, 0);
      $display("test subregion done");
   endtask : t_subregion
   // Vector area redirect, the first address past it, then redirect off.
   task automatic t_remap();
      remap_en_i = 1'b1;
      acc(0, 32'h0000_0010, 1, 32'h1000_0010, 0, 0);
      acc(0, 32'h0000_0400, 1, 32'h0000_0400, 0, 0);
      remap_en_i = 1'b0;
      acc(0, 32'h0000_0010, 1, 32'h0000_0010, 0, 0);
      $display("test remap done");
   endtask : t_remap
   // Slow target with a write then a read in a row.
   task automatic t_slow();
      delay = 4'h3;
      acc(1, 32'h4000_0000, 1, 32'h4000_0000, 2, 0);
      acc(0, 32'h5007_FFFC, 1, 32'h5007_FFFC, 1, 31);
      delay = 4'h0;
      $display("test slow target done");
   endtask : t_slow
   // Reset in the middle of a slow transfer returns every output to idle.
   task automatic t_midreset();
      delay = 4'h7;
      @(negedge clk_sys_i);
      req_valid_i = 1'b1;
      req_write_i = 1'b1;
      req_addr_i = 32'h4000_0000;
      repeat (2) @(negedge clk_sys_i);
      check(32'(tgt_valid_o), 32'h1, "busy before reset");
      reset_i = 1'b1;
      req_valid_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      reset_i = 1'b0;
      check(32'({tgt_valid_o, rsp_done_o, rsp_error_o, fault_o}), 32'h0, "reset idle");
      delay = 4'h0;
      $display("test mid-run reset done");
   endtask : t_midreset
   // Main sequence: configure, reset for 8 cycles, then each scenario.
   initial begin
      set_reg(0, 32'h0000_0000, 5'h1D, 8'h80, RPD_PERM_RW);
      set_reg(1, 32'h4000_0000, 5'h14, 8'h00, RPD_PERM_RW);
      set_reg(2, 32'h5000_0000, 5'h15, 8'h00, RPD_PERM_RW);
      set_reg(3, 32'h5000_0000, 5'h0E, 8'h00, RPD_PERM_RO);
      set_reg(4, 32'h4000_8000, 5'h0E, 8'h00, RPD_PERM_NONE);
      repeat (8) @(negedge clk_sys_i);
      reset_i = 1'b0;
      t_reset();
      t_decode();
      t_unmapped();
      t_readonly();
      t_disabled();
      t_subregion();
      t_remap();
      t_slow();
      t_midreset();
      t_decode();
      stop_test();
   end
endmodule : tb_rpd_top
